// ---- hdl/ombs_pkg.sv ----
// Constants for the operating mode and boot select block.
// Assumes a single 100 MHz system clock and an 8-bit register port.
package ombs_pkg;

    // =========================================================
    // Clock and serial timing
    // =========================================================
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
    localparam int unsigned BAUD_HI       = 7812;
    localparam int unsigned BAUD_LO       = 1200;
    localparam int unsigned BIT_CYC_HI_DEF = CLK_HZ / BAUD_HI;
    localparam int unsigned BIT_CYC_LO_DEF = CLK_HZ / BAUD_LO;
    localparam int unsigned IDLE_TO_US     = 5000;
    localparam int unsigned IDLE_TO_CYC_DEF = (IDLE_TO_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W         = 20;

    // =========================================================
    // Register port
    // =========================================================
    localparam int unsigned RA_W = 4;
    localparam int unsigned RD_W = 8;
    localparam logic [RA_W-1:0] OFS_PRIORITY_MODE = 4'h0;
    localparam logic [RA_W-1:0] OFS_NV_SETUP      = 4'h1;
    localparam logic [RA_W-1:0] OFS_LOAD_STATUS   = 4'h2;
    localparam logic [RA_W-1:0] OFS_LOAD_COUNT    = 4'h3;

    // Priority mode fields
    localparam int unsigned BIT_EXPANDED = 0;
    localparam int unsigned BIT_SPECIAL  = 1;
    localparam int unsigned BIT_BOOT_VIS = 2;

    // Load status fields
    localparam int unsigned BIT_BAUD_LO = 0;
    localparam int unsigned BIT_LOADING = 1;
    localparam int unsigned BIT_FINISH  = 2;
    localparam int unsigned BIT_ACTIVE  = 3;

    localparam logic [RD_W-1:0] NV_SETUP_RST = 8'h00;
    localparam logic [RD_W-1:0] RD_ZERO      = 8'h00;

    // =========================================================
    // Memory map
    // =========================================================
    localparam int unsigned CA_W = 16;
    localparam int unsigned VEC_REDIRECT_BIT = 14;
    localparam logic [CA_W-1:0] BOOT_ROM_BASE_DEF = 16'hBF40;
    localparam logic [CA_W-1:0] BOOT_ROM_LAST_DEF = 16'hBFFF;
    localparam logic [CA_W-1:0] RAM_BASE_DEF      = 16'h0000;
    localparam logic [7:0]      FIRST_CHAR        = 8'hFF;

    // Serial frame bit indices
    localparam logic [3:0] RX_START = 4'h0;
    localparam logic [3:0] RX_LAST  = 4'h8;
    localparam logic [3:0] RX_STOP  = 4'h9;

    // Loader states
    typedef enum logic [5:0] {
        LD_ARM  = 6'b00_0001,
        LD_OFF  = 6'b00_0010,
        LD_BAUD = 6'b00_0100,
        LD_LOAD = 6'b00_1000,
        LD_JUMP = 6'b01_0000,
        LD_DONE = 6'b10_0000
    } ombs_ld_t;

endpackage

// ---- hdl/ombs_top.sv ----
// Operating mode select, boot ROM gating, vector redirection and boot loader.
// Assumes straps and serial receive are board pins; CPU address is synchronous.
// Summary of operation
// - Bootstrap reset takes its reset vector from the internal boot ROM.
// - Boot ROM appears in the map normally only after a bootstrap reset.
// - Boot ROM decode is gated by boot_rom_visible in priority_mode_reg.
// - Software may write boot_rom_visible in either special mode.
// - In normal modes boot_rom_visible is forced zero and read only.
// - expanded_select_bit takes mode_strap_a level when leaving reset.
// - expanded_select_bit zero means single-chip, one means expanded.
// - special_mode_bit takes the inverse of mode_strap_b when leaving reset.
// - special_mode_bit zero means normal, one means special mode.
// - Mode control bits are writable only while special_mode_bit is one.
// - Special modes fetch vectors from the alternate BFxx page.
// - Alternate vectors come from forcing A14 low on vector fetches.
// - Special bootstrap sets boot_rom_visible so the loader takes control.
// - Special test fetches the redirected reset vector from external memory.
// - First serial character of all ones selects one of two baud rates.
// - Downloaded bytes from the serial port are stored into on-chip RAM.
// - After download ends, control jumps to the program loaded in RAM.
// - Bootstrap software may rewrite mode bits, e.g. to enable expansion.
// - Nonvolatile setup register is programmable while in bootstrap mode.
// - boot_rom_visible resets to one in bootstrap, zero in other modes.
`timescale 1ns/1ns

module ombs_top #(
    parameter int unsigned BIT_CYC_HI  = ombs_pkg::BIT_CYC_HI_DEF,
    parameter int unsigned BIT_CYC_LO  = ombs_pkg::BIT_CYC_LO_DEF,
    parameter int unsigned IDLE_TO_CYC = ombs_pkg::IDLE_TO_CYC_DEF,
    parameter int unsigned RAM_AW      = 8,
    parameter logic [15:0] BOOT_BASE   = ombs_pkg::BOOT_ROM_BASE_DEF,
    parameter logic [15:0] BOOT_LAST   = ombs_pkg::BOOT_ROM_LAST_DEF,
    parameter logic [15:0] RAM_BASE    = ombs_pkg::RAM_BASE_DEF
) (
    input  wire logic                        I_SYS_CLK,
    input  wire logic                        I_RST,
    input  wire logic                        I_MODE_STRAP_A,
    input  wire logic                        I_MODE_STRAP_B,
    input  wire logic                        I_SER_RXD,
    input  wire logic [ombs_pkg::RA_W-1:0]   I_REG_ADDR,
    input  wire logic [ombs_pkg::RD_W-1:0]   I_REG_WDATA,
    input  wire logic                        I_REG_WR,
    input  wire logic                        I_REG_RD,
    output logic      [ombs_pkg::RD_W-1:0]   O_REG_RDATA,
    input  wire logic [ombs_pkg::CA_W-1:0]   I_CPU_ADDR,
    input  wire logic                        I_VEC_FETCH,
    output logic      [ombs_pkg::CA_W-1:0]   O_MEM_ADDR,
    output logic                             O_BOOT_ROM_SEL,
    output logic                             O_EXT_SEL,
    output logic                             O_EXPANDED,
    output logic                             O_SPECIAL,
    output logic                             O_BOOT_ROM_VISIBLE,
    output logic      [ombs_pkg::RD_W-1:0]   O_NV_SETUP,
    output logic                             O_NV_PROG,
    output logic                             O_RAM_WE,
    output logic      [RAM_AW-1:0]           O_RAM_ADDR,
    output logic      [7:0]                  O_RAM_WDATA,
    output logic                             O_JUMP,
    output logic      [ombs_pkg::CA_W-1:0]   O_JUMP_ADDR
);
    import ombs_pkg::*;

    // =========================================================
    // Pin synchronisers
    // =========================================================
    logic [2:0] strap_a_sync;
    logic [2:0] strap_b_sync;
    logic [2:0] rxd_sync;
    logic       strap_a_lvl_ff;
    logic       strap_b_lvl_ff;
    logic       rxd_lvl_ff;

    always_ff @(posedge I_SYS_CLK) begin
        strap_a_sync <= {strap_a_sync[1:0], I_MODE_STRAP_A};
        strap_b_sync <= {strap_b_sync[1:0], I_MODE_STRAP_B};
        rxd_sync     <= {rxd_sync[1:0], I_SER_RXD};
    end

    wire strap_a_agree = strap_a_sync[1] == strap_a_sync[2];
    wire strap_b_agree = strap_b_sync[1] == strap_b_sync[2];
    wire rxd_agree     = rxd_sync[1] == rxd_sync[2];

    always_ff @(posedge I_SYS_CLK) begin
        if (strap_a_agree) begin
            strap_a_lvl_ff <= strap_a_sync[2];
        end
        if (strap_b_agree) begin
            strap_b_lvl_ff <= strap_b_sync[2];
        end
        if (I_RST) begin
            rxd_lvl_ff <= 1'b1;
        end else if (rxd_agree) begin
            rxd_lvl_ff <= rxd_sync[2];
        end
    end

    // =========================================================
    // Mode control bits
    // =========================================================
    logic expanded_select_bit_ff;
    logic special_mode_bit_ff;
    logic boot_rom_visible_ff;
    logic [RD_W-1:0] nv_setup_ff;
    logic nv_prog_ff;

    wire wr_prio = I_REG_WR && (I_REG_ADDR == OFS_PRIORITY_MODE);
    wire wr_nv   = I_REG_WR && (I_REG_ADDR == OFS_NV_SETUP);

    // Mode bits only move under special privilege
    wire mode_wr_ok = wr_prio && special_mode_bit_ff;
    wire nxt_expanded_select_bit = mode_wr_ok ? I_REG_WDATA[BIT_EXPANDED]
                                              : expanded_select_bit_ff;
    wire nxt_special_mode_bit    = mode_wr_ok ? I_REG_WDATA[BIT_SPECIAL]
                                              : special_mode_bit_ff;
    // Normal mode clamps visibility low
    wire nxt_boot_rom_visible    = !nxt_special_mode_bit ? 1'b0 :
                                   mode_wr_ok ? I_REG_WDATA[BIT_BOOT_VIS] :
                                   boot_rom_visible_ff;

    // Strap derived reset values
    wire rst_expanded = strap_a_lvl_ff;
    wire rst_special  = !strap_b_lvl_ff;
    wire rst_boot_vis = rst_special && !rst_expanded;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            expanded_select_bit_ff <= rst_expanded;
            special_mode_bit_ff    <= rst_special;
            boot_rom_visible_ff    <= rst_boot_vis;
        end else begin
            expanded_select_bit_ff <= nxt_expanded_select_bit;
            special_mode_bit_ff    <= nxt_special_mode_bit;
            boot_rom_visible_ff    <= nxt_boot_rom_visible;
        end
    end

    // Setup register programmable only with privilege
    wire nv_wr_ok = wr_nv && special_mode_bit_ff;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            nv_setup_ff <= NV_SETUP_RST;
            nv_prog_ff  <= 1'b0;
        end else begin
            nv_setup_ff <= nv_wr_ok ? I_REG_WDATA : nv_setup_ff;
            nv_prog_ff  <= nv_wr_ok;
        end
    end

    // =========================================================
    // Address path: vector redirect and boot ROM decode
    // =========================================================
    logic [CA_W-1:0] mem_addr_ff;
    logic            boot_sel_ff;
    logic            ext_sel_ff;

    // Special modes pull A14 low on vector fetch: FFxx becomes BFxx
    wire redirect = I_VEC_FETCH && special_mode_bit_ff;
    wire [CA_W-1:0] eff_addr = redirect ?
        (I_CPU_ADDR & ~(16'h0001 << VEC_REDIRECT_BIT)) : I_CPU_ADDR;
    wire in_boot_win = (eff_addr >= BOOT_BASE) && (eff_addr <= BOOT_LAST);
    wire boot_hit    = in_boot_win && boot_rom_visible_ff;
    // Without the boot ROM, expanded modes send the access off chip
    wire ext_hit     = expanded_select_bit_ff && !boot_hit;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            mem_addr_ff <= '0;
            boot_sel_ff <= 1'b0;
            ext_sel_ff  <= 1'b0;
        end else begin
            mem_addr_ff <= eff_addr;
            boot_sel_ff <= boot_hit;
            ext_sel_ff  <= ext_hit;
        end
    end

    // =========================================================
    // Serial receiver, two selectable bit times
    // =========================================================
    logic            baud_lo_ff;
    logic            rx_busy_ff;
    logic [CNT_W-1:0] rx_cnt_ff;
    logic [3:0]      rx_bit_ff;
    logic [7:0]      rx_sh_ff;
    logic            rx_done_ff;
    logic            nxt_rx_busy;
    logic [CNT_W-1:0] nxt_rx_cnt;
    logic [3:0]      nxt_rx_bit;
    logic [7:0]      nxt_rx_sh;
    logic            nxt_rx_done;
    ombs_ld_t        ld_state_ff;
    ombs_ld_t        nxt_ld_state;

    wire [CNT_W-1:0] bit_cyc  = baud_lo_ff ? CNT_W'(BIT_CYC_LO) : CNT_W'(BIT_CYC_HI);
    wire [CNT_W-1:0] half_cyc = bit_cyc >> 1;
    wire             rx_en    = (ld_state_ff == LD_BAUD) || (ld_state_ff == LD_LOAD);
    wire             rx_tick  = rx_busy_ff && (rx_cnt_ff == '0);

    always_comb begin
        nxt_rx_busy = rx_busy_ff;
        nxt_rx_cnt  = rx_cnt_ff;
        nxt_rx_bit  = rx_bit_ff;
        nxt_rx_sh   = rx_sh_ff;
        nxt_rx_done = 1'b0;
        if (!rx_en) begin
            nxt_rx_busy = 1'b0;
        end else if (!rx_busy_ff) begin
            if (!rxd_lvl_ff) begin
                nxt_rx_busy = 1'b1;
                nxt_rx_cnt  = half_cyc - CNT_W'(1);
                nxt_rx_bit  = RX_START;
            end
        end else if (!rx_tick) begin
            nxt_rx_cnt = rx_cnt_ff - CNT_W'(1);
        end else if (rx_bit_ff == RX_START) begin
            // False start drops back to idle
            nxt_rx_busy = !rxd_lvl_ff;
            nxt_rx_cnt  = bit_cyc - CNT_W'(1);
            nxt_rx_bit  = rx_bit_ff + 4'h1;
        end else if (rx_bit_ff <= RX_LAST) begin
            nxt_rx_sh  = {rxd_lvl_ff, rx_sh_ff[7:1]};
            nxt_rx_cnt = bit_cyc - CNT_W'(1);
            nxt_rx_bit = rx_bit_ff + 4'h1;
        end else begin
            // Stop bit: framing error discards the byte
            nxt_rx_busy = 1'b0;
            nxt_rx_done = rxd_lvl_ff;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            rx_busy_ff <= 1'b0;
            rx_cnt_ff  <= '0;
            rx_bit_ff  <= RX_START;
            rx_sh_ff   <= '0;
            rx_done_ff <= 1'b0;
        end else begin
            rx_busy_ff <= nxt_rx_busy;
            rx_cnt_ff  <= nxt_rx_cnt;
            rx_bit_ff  <= nxt_rx_bit;
            rx_sh_ff   <= nxt_rx_sh;
            rx_done_ff <= nxt_rx_done;
        end
    end

    // =========================================================
    // Boot loader sequence
    // =========================================================
    logic [CNT_W-1:0]  idle_cnt_ff;
    logic [RAM_AW-1:0] ram_addr_ff;
    logic              ram_we_ff;
    logic [7:0]        ram_wdata_ff;
    logic              jump_ff;
    logic              nxt_baud_lo;

    wire boot_mode  = special_mode_bit_ff && !expanded_select_bit_ff;
    wire ram_full   = ram_addr_ff == {RAM_AW{1'b1}};
    wire idle_out   = idle_cnt_ff >= CNT_W'(IDLE_TO_CYC);
    wire store_byte = (ld_state_ff == LD_LOAD) && rx_done_ff;

    always_comb begin
        nxt_ld_state = ld_state_ff;
        nxt_baud_lo  = baud_lo_ff;
        case (ld_state_ff)
            LD_ARM: begin
                nxt_ld_state = boot_mode ? LD_BAUD : LD_OFF;
            end
            LD_BAUD: begin
                if (rx_done_ff) begin
                    // Slow all-ones frame reads as a smaller value at the fast rate
                    nxt_baud_lo  = rx_sh_ff != FIRST_CHAR;
                    nxt_ld_state = LD_LOAD;
                end
            end
            LD_LOAD: begin
                if ((store_byte && ram_full) || (!rx_done_ff && idle_out)) begin
                    nxt_ld_state = LD_JUMP;
                end
            end
            LD_JUMP: begin
                nxt_ld_state = LD_DONE;
            end
            default: begin
                nxt_ld_state = ld_state_ff;
            end
        endcase
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            ld_state_ff <= LD_ARM;
            baud_lo_ff  <= 1'b0;
        end else begin
            ld_state_ff <= nxt_ld_state;
            baud_lo_ff  <= nxt_baud_lo;
        end
    end

    wire idle_clr = rx_done_ff || rx_busy_ff || (ld_state_ff != LD_LOAD);

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            idle_cnt_ff  <= '0;
            ram_addr_ff  <= '0;
            ram_we_ff    <= 1'b0;
            ram_wdata_ff <= '0;
            jump_ff      <= 1'b0;
        end else begin
            idle_cnt_ff  <= idle_clr ? '0 : idle_cnt_ff + CNT_W'(1);
            ram_we_ff    <= store_byte;
            ram_wdata_ff <= store_byte ? rx_sh_ff : ram_wdata_ff;
            ram_addr_ff  <= ram_we_ff ? ram_addr_ff + RAM_AW'(1) : ram_addr_ff;
            jump_ff      <= ld_state_ff == LD_JUMP;
        end
    end

    // =========================================================
    // Register read port
    // =========================================================
    logic [RD_W-1:0] rdata_ff;

    wire [RD_W-1:0] rd_prio = RD_W'({boot_rom_visible_ff, special_mode_bit_ff,
                                     expanded_select_bit_ff});
    wire [RD_W-1:0] rd_stat = RD_W'({ld_state_ff == LD_LOAD || ld_state_ff == LD_BAUD,
                                     ld_state_ff == LD_DONE,
                                     ld_state_ff == LD_LOAD,
                                     baud_lo_ff});
    wire [RD_W-1:0] rd_cnt  = RD_W'(ram_addr_ff);
    wire [RD_W-1:0] rd_mux  =
        (I_REG_ADDR == OFS_PRIORITY_MODE) ? rd_prio :
        (I_REG_ADDR == OFS_NV_SETUP)      ? nv_setup_ff :
        (I_REG_ADDR == OFS_LOAD_STATUS)   ? rd_stat :
        (I_REG_ADDR == OFS_LOAD_COUNT)    ? rd_cnt : RD_ZERO;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            rdata_ff <= RD_ZERO;
        end else begin
            rdata_ff <= I_REG_RD ? rd_mux : RD_ZERO;
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    assign O_REG_RDATA        = rdata_ff;
    assign O_MEM_ADDR         = mem_addr_ff;
    assign O_BOOT_ROM_SEL     = boot_sel_ff;
    assign O_EXT_SEL          = ext_sel_ff;
    assign O_EXPANDED         = expanded_select_bit_ff;
    assign O_SPECIAL          = special_mode_bit_ff;
    assign O_BOOT_ROM_VISIBLE = boot_rom_visible_ff;
    assign O_NV_SETUP         = nv_setup_ff;
    assign O_NV_PROG          = nv_prog_ff;
    assign O_RAM_WE           = ram_we_ff;
    assign O_RAM_ADDR         = ram_addr_ff;
    assign O_RAM_WDATA        = ram_wdata_ff;
    assign O_JUMP             = jump_ff;
    assign O_JUMP_ADDR        = RAM_BASE;

endmodule // ombs_top

// ---- tb/ombs_host.sv ----
// Far-side model: board mode straps and the serial download host.
// Assumes the bench clock; drives its lines just after rising edges.
`timescale 1ns/1ns

module ombs_host (
    input  wire logic i_clk,
    output logic      o_strap_a,
    output logic      o_strap_b,
    output logic      o_rxd
);
    // =========================================================
    // Strap levels and idle serial line
    // =========================================================
    initial begin
        o_strap_a = 1'b0;
        o_strap_b = 1'b1;
        o_rxd     = 1'b1;
    end

    task automatic set_straps(input logic a, input logic b);
        @(posedge i_clk);
        o_strap_a <= a;
        o_strap_b <= b;
    endtask

    // =========================================================
    // One 8N1 frame, LSB first; line returns high after stop
    // =========================================================
    task automatic send(input logic [7:0] b, input int bc);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_clk);
            o_rxd <= f[i];
            repeat (bc - 1) @(posedge i_clk);
        end
    endtask
endmodule // ombs_host

// ---- tb/ombs_asserts.sv ----
// Checker on the top module ports of the mode and boot select block.
// Assumes one clock domain and synchronous active-high reset.
`timescale 1ns/1ns

module ombs_asserts (
    input wire logic        I_SYS_CLK,
    input wire logic        I_RST,
    input wire logic        I_MODE_STRAP_A,
    input wire logic        I_MODE_STRAP_B,
    input wire logic [3:0]  I_REG_ADDR,
    input wire logic [7:0]  I_REG_WDATA,
    input wire logic        I_REG_WR,
    input wire logic [15:0] I_CPU_ADDR,
    input wire logic        I_VEC_FETCH,
    input wire logic [15:0] O_MEM_ADDR,
    input wire logic        O_BOOT_ROM_SEL,
    input wire logic        O_EXT_SEL,
    input wire logic        O_EXPANDED,
    input wire logic        O_SPECIAL,
    input wire logic        O_BOOT_ROM_VISIBLE,
    input wire logic        O_NV_PROG,
    input wire logic        O_RAM_WE,
    input wire logic        O_JUMP,
    input wire logic [15:0] O_JUMP_ADDR
);
    // =========================================================
    // Helper logic
    // =========================================================
    logic [2:0] wd_ff;
    wire [15:0] eff_addr = (I_VEC_FETCH && O_SPECIAL) ? (I_CPU_ADDR & 16'hBFFF) : I_CPU_ADDR;
    wire        rom_hit  = O_BOOT_ROM_VISIBLE && eff_addr >= 16'hBF40 && eff_addr <= 16'hBFFF;
    wire        ext_exp  = O_EXPANDED && !rom_hit;
    wire        mode_wr  = I_REG_WR && O_SPECIAL && I_REG_ADDR == 4'h0;
    always_ff @(posedge I_SYS_CLK) wd_ff <= I_REG_WDATA[2:0];

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);

    // =========================================================
    // Assertions
    // =========================================================
    a_addr_redirect: assert property (!I_RST |=> O_MEM_ADDR == $past(eff_addr))
        else $error("memory address not redirected as expected");
    a_rom_gate: assert property (!I_RST |=> O_BOOT_ROM_SEL == $past(rom_hit))
        else $error("boot rom select wrong");
    a_ext_select: assert property (!I_RST |=> O_EXT_SEL == $past(ext_exp))
        else $error("external select wrong");
    a_normal_vis: assert property (!O_SPECIAL |-> !O_BOOT_ROM_VISIBLE)
        else $error("boot rom visible in a normal mode");
    a_mode_load: assert property ($fell(I_RST) |->
        O_EXPANDED == I_MODE_STRAP_A && O_SPECIAL == !I_MODE_STRAP_B)
        else $error("mode bits not loaded from straps");
    a_vis_reset: assert property ($fell(I_RST) |->
        O_BOOT_ROM_VISIBLE == (!I_MODE_STRAP_A && !I_MODE_STRAP_B))
        else $error("boot rom visible reset value wrong");
    a_mode_hold: assert property (!$past(I_RST) && !($past(I_REG_WR) && $past(O_SPECIAL)
        && $past(I_REG_ADDR) == 4'h0) |-> $stable({O_EXPANDED, O_SPECIAL, O_BOOT_ROM_VISIBLE}))
        else $error("mode bits changed without a privileged write");
    a_mode_write: assert property (mode_wr |=> {O_BOOT_ROM_VISIBLE, O_SPECIAL, O_EXPANDED}
        == (wd_ff[1] ? wd_ff : {1'b0, wd_ff[1:0]}))
        else $error("privileged mode write not applied");
    a_nv_prog: assert property (O_NV_PROG == ($past(I_REG_WR) && $past(O_SPECIAL)
        && $past(I_REG_ADDR) == 4'h1))
        else $error("setup programming pulse wrong");
    a_jump_pulse: assert property (O_JUMP |-> O_JUMP_ADDR == 16'h0000 ##1 !O_JUMP)
        else $error("jump pulse or target wrong");

    c_jump: cover property (O_JUMP);
    c_ram_we: cover property (O_RAM_WE);
    c_rom_sel: cover property (O_BOOT_ROM_SEL);
endmodule // ombs_asserts

bind ombs_top ombs_asserts u_ombs_asserts (
    .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_MODE_STRAP_A(I_MODE_STRAP_A),
    .I_MODE_STRAP_B(I_MODE_STRAP_B), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
    .I_REG_WR(I_REG_WR), .I_CPU_ADDR(I_CPU_ADDR), .I_VEC_FETCH(I_VEC_FETCH),
    .O_MEM_ADDR(O_MEM_ADDR), .O_BOOT_ROM_SEL(O_BOOT_ROM_SEL), .O_EXT_SEL(O_EXT_SEL),
    .O_EXPANDED(O_EXPANDED), .O_SPECIAL(O_SPECIAL), .O_BOOT_ROM_VISIBLE(O_BOOT_ROM_VISIBLE),
    .O_NV_PROG(O_NV_PROG), .O_RAM_WE(O_RAM_WE), .O_JUMP(O_JUMP), .O_JUMP_ADDR(O_JUMP_ADDR)
);

// ---- tb/tb.sv ----
// Self-checking bench for the mode select and boot loader block.
// Assumes the host model drives straps and serial; short loader counts.
`timescale 1ns/1ns

module tb;
    import ombs_pkg::*;
    `define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
        $display("mismatch %s expected %0h seen %0h", n, (e), (a)); end end

    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, vec = 1'b0, sa, sb, rxd;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00, d;
    logic [15:0] cpu = 16'h0000;
    logic [15:0] got[$];
    logic [4:0]  rows [4] = '{5'h10, 5'h1C, 5'h03, 5'h0E};
    logic [7:0]  dat [3] = '{8'hA5, 8'h3C, 8'h81};
    logic        e_exp, e_spc, e_vis, tb_a, tb_b;
    int          err_total = 0, cmp_count = 0;
    wire [7:0]   rdata, nv, ram_wd;
    wire [15:0]  mem_addr, jump_addr;
    wire [7:0]   ram_addr;
    wire         rom_sel, ext_sel, exp_o, spc_o, vis_o, jump, ram_we;

    ombs_host u_ombs_host (.i_clk(clk), .o_strap_a(sa), .o_strap_b(sb), .o_rxd(rxd));

    ombs_top #(.BIT_CYC_HI(40), .BIT_CYC_LO(260), .IDLE_TO_CYC(2800)) u_ombs_top (
        .I_SYS_CLK(clk), .I_RST(rst), .I_MODE_STRAP_A(sa), .I_MODE_STRAP_B(sb),
        .I_SER_RXD(rxd), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr),
        .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_CPU_ADDR(cpu), .I_VEC_FETCH(vec),
        .O_MEM_ADDR(mem_addr), .O_BOOT_ROM_SEL(rom_sel), .O_EXT_SEL(ext_sel),
        .O_EXPANDED(exp_o), .O_SPECIAL(spc_o), .O_BOOT_ROM_VISIBLE(vis_o),
        .O_NV_SETUP(nv), .O_NV_PROG(), .O_RAM_WE(ram_we), .O_RAM_ADDR(ram_addr),
        .O_RAM_WDATA(ram_wd), .O_JUMP(jump), .O_JUMP_ADDR(jump_addr));

    // =========================================================
    // Clock, capture of stored bytes, watchdog
    // =========================================================
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (ram_we === 1'b1) got.push_back({ram_addr, ram_wd});
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        end_sim();
    end

    // =========================================================
    // Bus and sequencing tasks
    // =========================================================
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic reset_to(input logic a, input logic b);
        u_ombs_host.set_straps(a, b);
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        cyc(2);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic fetch(input logic [15:0] a, input logic v);
        @(posedge clk);
        cpu <= a; vec <= v;
        @(posedge clk);
        vec <= 1'b0;
        #1;
    endtask
    task automatic dl(input int bc, input int n);
        int k;
        got.delete();
        u_ombs_host.send(8'hFF, bc);
        for (k = 0; k < n; k++) u_ombs_host.send(dat[k], bc);
        for (k = 0; k < 3000 && jump !== 1'b1; k++) cyc(1);
        `CHK("jump", 1'b1, jump)
        `CHK("jump address", 16'h0000, jump_addr)
        `CHK("byte count", n, got.size())
        for (k = 0; k < n; k++) `CHK("ram byte", {k[7:0], dat[k]}, got[k])
        rd_reg(4'h3);
        `CHK("load count", n, d)
        rd_reg(4'h2);
        `CHK("load status", (bc == 40) ? 8'h04 : 8'h05, d)
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // =========================================================
    // Mode table, then download at both rates
    // =========================================================
    initial begin
        for (int r = 0; r < 4; r++) begin
            {tb_b, tb_a, e_exp, e_spc, e_vis} = rows[r];
            reset_to(tb_a, tb_b);
            `CHK("expanded", e_exp, exp_o)
            `CHK("special", e_spc, spc_o)
            `CHK("visible", e_vis, vis_o)
            u_ombs_host.set_straps(!tb_a, !tb_b);
            cyc(6);
            `CHK("strap hold", {e_exp, e_spc}, {exp_o, spc_o})
            fetch(16'hFFFE, 1'b1);
            `CHK("vector address", e_spc ? 16'hBFFE : 16'hFFFE, mem_addr)
            `CHK("vector rom", e_vis && e_spc, rom_sel)
            `CHK("vector ext", e_exp && !e_vis, ext_sel)
            fetch(16'hBF80, 1'b0);
            `CHK("rom gate", e_vis, rom_sel)
            `CHK("ext gate", e_exp && !e_vis, ext_sel)
            wr_reg(4'h0, 8'h07);
            rd_reg(4'h0);
            `CHK("mode reg", e_spc ? 8'h07 : {7'h00, e_exp}, d)
            wr_reg(4'h1, 8'h5A);
            cyc(1);
            `CHK("setup reg", e_spc ? 8'h5A : 8'h00, nv)
            rd_reg(4'hF);
            `CHK("unmapped", 8'h00, d)
        end
        reset_to(1'b0, 1'b0);
        dl(40, 3);
        reset_to(1'b0, 1'b0);
        dl(260, 2);
        end_sim();
    end
endmodule // tb
